// ### pkg/bridge_cfg_pkg.sv
/*
 * Constants and carrier types for the bridge configuration header block:
 * dword indices, command field positions, masks, reset values, VGA palette
 * addresses and the packed structs of the configuration and bus ports.
 * Assumes a single 100 MHz clock domain; compiled before every design file.
 */
package bridge_cfg_pkg;

    // ============================================================
    // Configuration space geometry
    localparam int          CFG_DWORDS    = 64;
    localparam int          CFG_DW_AW     = 6;
    localparam logic [7:0]  OFF_IDENT     = 8'h00;
    localparam logic [7:0]  OFF_CMD       = 8'h04;
    localparam logic [5:0]  DW_IDENT      = 6'(OFF_IDENT >> 2);
    localparam logic [5:0]  DW_CMD        = 6'(OFF_CMD >> 2);

    // ============================================================
    // Identity field positions
    localparam int          MAKER_LSB     = 0;
    localparam int          PART_LSB      = 16;

    // ============================================================
    // Command register fields
    localparam int          CMD_WIDTH     = 16;
    localparam int          CMD_IO_EN     = 0;
    localparam int          CMD_MEM_EN    = 1;
    localparam int          CMD_MASTER_EN = 2;
    localparam int          CMD_SPECIAL   = 3;
    localparam int          CMD_MWI       = 4;
    localparam int          CMD_VGA_SNOOP = 5;
    localparam int          CMD_PAR_RESP  = 6;
    localparam int          CMD_STEPPING  = 7;
    localparam int          CMD_SERR_EN   = 8;
    localparam int          CMD_FBB       = 9;
    localparam int          CMD_RSVD_LSB  = 10;
    localparam logic [15:0] CMD_RW_MASK   = 16'h0167;
    localparam logic [15:0] CMD_W1C_MASK  = 16'h0000;
    localparam logic [15:0] CMD_RESET     = 16'h0000;

    // ============================================================
    // VGA palette snoop decode
    localparam int          VGA_ADDR_BITS = 10;
    localparam logic [9:0]  VGA_PAL_MASK  = 10'h3c6;
    localparam logic [9:0]  VGA_PAL_WADDR = 10'h3c8;
    localparam logic [9:0]  VGA_PAL_DATA  = 10'h3c9;

    // ============================================================
    // Carrier types
    typedef enum logic [1:0] {
        KIND_MEM,
        KIND_IO,
        KIND_SPECIAL,
        KIND_OTHER
    } txn_kind_e;

    typedef struct packed {
        logic        valid;
        txn_kind_e   kind;
        logic        write;
        logic        in_window;
        logic [31:0] addr;
    } bus_txn_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [5:0]  dword;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

endpackage

// ### verilog/cfg_field_reg.sv
/*
 * One configuration register of up to 32 bits, built bit by bit from masks:
 * read-write, write-one-to-clear with a hardware set, or fixed read-only.
 * Assumes byte enables per 8-bit lane and a clock enable that freezes state.
 */
`timescale 1ns/100ps

module cfg_field_reg #(
    parameter int                WIDTH     = 16,
    parameter logic [WIDTH-1:0]  RW_MASK   = '0,
    parameter logic [WIDTH-1:0]  W1C_MASK  = '0,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Write side
    input  wire logic                   wr_en_i,
    input  wire logic [(WIDTH+7)/8-1:0] wr_be_i,
    input  wire logic [WIDTH-1:0]       wr_data_i,
    // Hardware events for write-one-to-clear bits
    input  wire logic [WIDTH-1:0]       hw_set_i,
    // Current value
    output logic      [WIDTH-1:0]       value_o
);

    logic [WIDTH-1:0] val_q;

    assign value_o = val_q;

    // ============================================================
    // Per-bit storage
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        wire lane_wr = wr_en_i & wr_be_i[i/8];
        wire set_hit = hw_set_i[i] & W1C_MASK[i];
        wire clr_hit = lane_wr & wr_data_i[i] & W1C_MASK[i];
        wire rw_hit  = lane_wr & RW_MASK[i];

        always_ff @(posedge sys_clk_i or posedge rst_i)
        begin
            if (rst_i)
                val_q[i] <= RESET_VAL[i];
            else if (ce_i)
            begin
                if (set_hit)
                    val_q[i] <= 1'b1;         // Set beats clear [RULE1]
                else if (clr_hit)
                    val_q[i] <= 1'b0;         // [RULE1]
                else if (rw_hit)
                    val_q[i] <= wr_data_i[i];
            end
        end

        a_w1c_clear_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE1]
            ce_i && clr_hit && !set_hit |=> !val_q[i])
            else $error("write-one-to-clear bit did not clear");

        a_ro_bit_fixed: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE17]
            !RW_MASK[i] && !W1C_MASK[i] |-> val_q[i] == RESET_VAL[i])
            else $error("read-only bit changed");
    end

endmodule

// ### verilog/pri_target_decode.sv
/*
 * Target claim decode for the primary bus: memory and I/O windows gated by
 * the command enables, VGA palette write snooping, no special cycles.
 * Assumes the caller supplies the window hit and registers the result.
 */
`timescale 1ns/100ps

module pri_target_decode (
    // Transaction seen on the primary bus
    input  wire bridge_cfg_pkg::bus_txn_s txn_i,
    // Command enables
    input  wire logic                     mem_en_i,
    input  wire logic                     io_en_i,
    input  wire logic                     vga_snoop_i,
    // Decode results
    output logic                          claim_o,
    output logic                          vga_hit_o
);

    wire [9:0] io_low   = txn_i.addr[bridge_cfg_pkg::VGA_ADDR_BITS-1:0];
    wire       is_mem   = txn_i.valid && (txn_i.kind == bridge_cfg_pkg::KIND_MEM);
    wire       is_io    = txn_i.valid && (txn_i.kind == bridge_cfg_pkg::KIND_IO);
    wire       pal_addr = (io_low == bridge_cfg_pkg::VGA_PAL_MASK)
                        || (io_low == bridge_cfg_pkg::VGA_PAL_WADDR)
                        || (io_low == bridge_cfg_pkg::VGA_PAL_DATA);

    wire       mem_hit  = is_mem && mem_en_i && txn_i.in_window;                // [RULE14]
    wire       io_hit   = is_io && io_en_i && txn_i.in_window;                  // [RULE15]

    // Upper I/O bits are aliases and not decoded
    assign vga_hit_o = is_io && txn_i.write && vga_snoop_i && pal_addr;         // [RULE9]

    // Special cycles never reach any term here
    assign claim_o   = mem_hit || io_hit || vga_hit_o;                          // [RULE11]

endmodule

// ### verilog/bridge_config_header_command.sv
/*
 * Start of the bridge configuration header: identity dword and command
 * register, reached by configuration accesses on the primary bus, plus the
 * gating that the command bits impose on target claims, mastering, parity
 * response and the open-drain system error driver.
 * Assumes every input is synchronous to sys_clk_i and that ce_i freezes state.
 */
// What this block does
// RULE1: Write-one-to-clear bits clear on a written 1, stay on 0.
// RULE2: Dword 0 bits 15:0 return a fixed read-only maker code.
// RULE3: Dword 0 bits 31:16 return a fixed read-only part code.
// RULE4: Command bits 15:10 are reserved and always read zero.
// RULE5: Command bit 9 reads zero; no fast back-to-back initiation.
// RULE6: Command bit 8, reset 0, enables the primary system error driver.
// RULE7: Command bit 7 reads zero; no address or data stepping.
// RULE8: Command bit 6, reset 0, enables normal parity error action.
// RULE9: Command bit 5 snoops I/O writes to 3C6h, 3C8h, 3C9h, aliases included.
// RULE10: Command bit 4 reads zero; no memory write and invalidate.
// RULE11: Command bit 3 reads zero; special cycles are never claimed.
// RULE12: Command bit 2 gates primary mastering and secondary memory/I/O claims.
// RULE13: In PCI-X mode split completions start regardless of bit 2.
// RULE14: Command bit 1, reset 0, enables primary memory claims.
// RULE15: Command bit 0, reset 0, enables primary I/O claims.
// RULE16: Configuration space spans 64 dwords; unimplemented dwords read zero.
// RULE17: Writes to read-only fields have no effect on later reads.
`timescale 1ns/100ps

module bridge_config_header_command #(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a,   // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0c0d    // Arbitrary value
) (
    // Clock, reset, clock enable
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // Configuration access port
    input  wire bridge_cfg_pkg::cfg_req_s cfg_req_i,
    output logic                          cfg_ack_o,
    output logic [31:0]                   cfg_rdata_o,
    // Primary bus target decode
    input  wire bridge_cfg_pkg::bus_txn_s pri_txn_i,
    output logic                          pri_claim_o,
    output logic                          pri_vga_claim_o,
    // Secondary bus target decode
    input  wire bridge_cfg_pkg::bus_txn_s sec_txn_i,
    output logic                          sec_claim_o,
    // Primary bus mastering
    input  wire logic                     pcix_mode_i,
    input  wire logic                     fwd_req_i,
    input  wire logic                     split_cpl_req_i,
    output logic                          pri_master_start_o,
    output logic                          pri_split_start_o,
    // Error handling
    input  wire logic                     parity_err_i,
    input  wire logic                     serr_event_i,
    output logic                          parity_action_o,
    output logic                          primary_system_error_out_o,
    output logic                          primary_system_error_out_oe_o,
    // Fixed capabilities
    output logic                          fbb_allowed_o,
    output logic                          stepping_allowed_o,
    output logic                          mwi_allowed_o
);

    // ============================================================
    // Command register
    logic [15:0] cmd_value;

    wire cmd_wr = cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.dword == bridge_cfg_pkg::DW_CMD);

    // Fixed bits hold their reset zero whatever is written
    cfg_field_reg #(
        .WIDTH     (bridge_cfg_pkg::CMD_WIDTH),
        .RW_MASK   (bridge_cfg_pkg::CMD_RW_MASK),
        .W1C_MASK  (bridge_cfg_pkg::CMD_W1C_MASK),
        .RESET_VAL (bridge_cfg_pkg::CMD_RESET)
    ) u_cmd_reg (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .wr_en_i   (cmd_wr),
        .wr_be_i   (cfg_req_i.be[1:0]),
        .wr_data_i (cfg_req_i.wdata[15:0]),
        .hw_set_i  (16'h0000),
        .value_o   (cmd_value)
    ); // [RULE4] [RULE17]

    wire io_en     = cmd_value[bridge_cfg_pkg::CMD_IO_EN];
    wire mem_en    = cmd_value[bridge_cfg_pkg::CMD_MEM_EN];
    wire master_en = cmd_value[bridge_cfg_pkg::CMD_MASTER_EN];
    wire vga_snoop = cmd_value[bridge_cfg_pkg::CMD_VGA_SNOOP];
    wire par_resp  = cmd_value[bridge_cfg_pkg::CMD_PAR_RESP];
    wire serr_en   = cmd_value[bridge_cfg_pkg::CMD_SERR_EN];

    // ============================================================
    // Configuration read mux
    wire [31:0] ident_dword = {PART_CODE, MAKER_CODE};                          // [RULE2] [RULE3]
    wire [31:0] cmd_dword   = {16'h0000, cmd_value};
    wire        rd_ident    = cfg_req_i.dword == bridge_cfg_pkg::DW_IDENT;
    wire        rd_cmd      = cfg_req_i.dword == bridge_cfg_pkg::DW_CMD;
    wire [31:0] rd_mux      = rd_ident ? ident_dword :
                              rd_cmd   ? cmd_dword   : 32'h0000_0000;           // [RULE16]
    wire [31:0] rdata_d     = (cfg_req_i.valid && !cfg_req_i.write) ? rd_mux : 32'h0000_0000;

    // ============================================================
    // Primary target decode
    logic pri_claim_d;
    logic pri_vga_d;

    pri_target_decode u_pri_decode (
        .txn_i       (pri_txn_i),
        .mem_en_i    (mem_en),
        .io_en_i     (io_en),
        .vga_snoop_i (vga_snoop),
        .claim_o     (pri_claim_d),
        .vga_hit_o   (pri_vga_d)
    );

    // ============================================================
    // Secondary claims and primary mastering
    wire sec_memio = sec_txn_i.valid && sec_txn_i.in_window
                   && ((sec_txn_i.kind == bridge_cfg_pkg::KIND_MEM) || (sec_txn_i.kind == bridge_cfg_pkg::KIND_IO));
    wire sec_claim_d    = sec_memio && master_en;                               // [RULE12]
    wire master_start_d = fwd_req_i && master_en;                               // [RULE12]
    wire split_start_d  = split_cpl_req_i && (pcix_mode_i || master_en);        // [RULE13]

    // ============================================================
    // Error responses
    wire parity_act_d = parity_err_i && par_resp;                               // [RULE8]
    wire serr_drive_d = serr_event_i && serr_en;                                // [RULE6]

    // Fixed capabilities follow the read-only-zero command bits
    wire fbb_d  = cmd_value[bridge_cfg_pkg::CMD_FBB];                           // [RULE5]
    wire step_d = cmd_value[bridge_cfg_pkg::CMD_STEPPING];                      // [RULE7]
    wire mwi_d  = cmd_value[bridge_cfg_pkg::CMD_MWI];                           // [RULE10]

    // ============================================================
    // Output registers
    logic        cfg_ack_q;
    logic [31:0] cfg_rdata_q;
    logic        pri_claim_q;
    logic        pri_vga_q;
    logic        sec_claim_q;
    logic        master_start_q;
    logic        split_start_q;
    logic        parity_act_q;
    logic        serr_oe_q;
    logic        serr_level_q;
    logic        fbb_q;
    logic        step_q;
    logic        mwi_q;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_ack_q   <= 1'b0;
            cfg_rdata_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            cfg_ack_q   <= cfg_req_i.valid;
            cfg_rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pri_claim_q    <= 1'b0;
            pri_vga_q      <= 1'b0;
            sec_claim_q    <= 1'b0;
            master_start_q <= 1'b0;
            split_start_q  <= 1'b0;
        end
        else if (ce_i)
        begin
            pri_claim_q    <= pri_claim_d;
            pri_vga_q      <= pri_vga_d;
            sec_claim_q    <= sec_claim_d;
            master_start_q <= master_start_d;
            split_start_q  <= split_start_d;
        end
    end

    // Open-drain driver pulls low only while enabled
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            parity_act_q <= 1'b0;
            serr_oe_q    <= 1'b0;
            serr_level_q <= 1'b0;
            fbb_q        <= 1'b0;
            step_q       <= 1'b0;
            mwi_q        <= 1'b0;
        end
        else if (ce_i)
        begin
            parity_act_q <= parity_act_d;
            serr_oe_q    <= serr_drive_d;
            serr_level_q <= 1'b0;
            fbb_q        <= fbb_d;
            step_q       <= step_d;
            mwi_q        <= mwi_d;
        end
    end

    assign cfg_ack_o                     = cfg_ack_q;
    assign cfg_rdata_o                   = cfg_rdata_q;
    assign pri_claim_o                   = pri_claim_q;
    assign pri_vga_claim_o               = pri_vga_q;
    assign sec_claim_o                   = sec_claim_q;
    assign pri_master_start_o            = master_start_q;
    assign pri_split_start_o             = split_start_q;
    assign parity_action_o               = parity_act_q;
    assign primary_system_error_out_o    = serr_level_q;
    assign primary_system_error_out_oe_o = serr_oe_q;
    assign fbb_allowed_o                 = fbb_q;
    assign stepping_allowed_o            = step_q;
    assign mwi_allowed_o                 = mwi_q;

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    wire cfg_rd = ce_i && cfg_req_i.valid && !cfg_req_i.write;

    a_maker_code_read: assert property ( // [RULE2]
        cfg_rd && rd_ident |=> cfg_ack_o && cfg_rdata_o[15:0] == MAKER_CODE)
        else $error("maker code read wrong");

    a_part_code_read: assert property ( // [RULE3]
        cfg_rd && rd_ident |=> cfg_ack_o && cfg_rdata_o[31:16] == PART_CODE)
        else $error("part code read wrong");

    a_cmd_reserved_zero: assert property ( // [RULE4]
        cfg_rd && rd_cmd |=> cfg_rdata_o[31:10] == 22'h00_0000)
        else $error("reserved command bits not zero");

    a_fixed_caps_off: assert property ( // [RULE5]
        !fbb_allowed_o && !stepping_allowed_o && !mwi_allowed_o
        && cmd_value[9] == 1'b0 && cmd_value[7] == 1'b0 && cmd_value[4] == 1'b0 && cmd_value[3] == 1'b0)
        else $error("read-only-zero command bit set");

    a_serr_gate: assert property ( // [RULE6]
        ce_i |=> primary_system_error_out_oe_o == ($past(serr_en) && $past(serr_event_i))
                 && !primary_system_error_out_o)
        else $error("system error driver gating wrong");

    a_parity_gate: assert property ( // [RULE8]
        ce_i && parity_err_i |=> parity_action_o == $past(par_resp))
        else $error("parity response gating wrong");

    a_parity_idle: assert property ( // [RULE8]
        ce_i && !parity_err_i |=> !parity_action_o)
        else $error("parity action without error");

    a_vga_alias_hit: assert property ( // [RULE9]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_IO && pri_txn_i.write && vga_snoop
        && (pri_txn_i.addr[9:0] == bridge_cfg_pkg::VGA_PAL_MASK
            || pri_txn_i.addr[9:0] == bridge_cfg_pkg::VGA_PAL_WADDR)
        |=> pri_claim_o && pri_vga_claim_o)
        else $error("palette alias write not claimed");

    a_vga_snoop_hit: assert property ( // [RULE9]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_IO && pri_txn_i.write
        && pri_txn_i.addr[9:0] == bridge_cfg_pkg::VGA_PAL_DATA && vga_snoop |=> pri_claim_o && pri_vga_claim_o)
        else $error("palette write not claimed");

    a_no_special_claim: assert property ( // [RULE11]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_SPECIAL |=> !pri_claim_o)
        else $error("special cycle claimed");

    a_master_gate: assert property ( // [RULE12]
        ce_i && !master_en |=> !pri_master_start_o && !sec_claim_o)
        else $error("mastering while bus master disabled");

    a_split_pcix: assert property ( // [RULE13]
        ce_i && split_cpl_req_i && pcix_mode_i |=> pri_split_start_o)
        else $error("split completion blocked in PCI-X mode");

    a_mem_gate: assert property ( // [RULE14]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_MEM |=> pri_claim_o == ($past(mem_en)
        && $past(pri_txn_i.in_window)))
        else $error("memory claim gating wrong");

    a_io_gate: assert property ( // [RULE15]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_IO && !io_en && !vga_snoop |=> !pri_claim_o)
        else $error("I/O claimed while disabled");

    a_io_claim_on: assert property ( // [RULE15]
        ce_i && pri_txn_i.valid && pri_txn_i.kind == bridge_cfg_pkg::KIND_IO && io_en && pri_txn_i.in_window
        |=> pri_claim_o)
        else $error("enabled I/O access not claimed");

    a_unmapped_zero: assert property ( // [RULE16]
        cfg_rd && !rd_ident && !rd_cmd |=> cfg_ack_o && cfg_rdata_o == 32'h0000_0000)
        else $error("unimplemented dword not zero");

    a_ro_write_ignored: assert property ( // [RULE17]
        ce_i && cmd_wr |=> (cmd_value & ~bridge_cfg_pkg::CMD_RW_MASK) == 16'h0000)
        else $error("read-only command bit written");

endmodule

// ### verification/cfg_master_model.sv
/*
 * Configuration master model on the primary bus: issues single-cycle
 * configuration reads and writes and collects the registered answer.
 * Assumes the block answers exactly one cycle after it takes a request.
 */
`timescale 1ns/100ps

module cfg_master_model (
    // Clock
    input  wire logic                 sys_clk_i,
    // Request and answer
    output bridge_cfg_pkg::cfg_req_s  cfg_req_o,
    input  wire logic                 cfg_ack_i,
    input  wire logic [31:0]          cfg_rdata_i
);
    initial
    begin
        cfg_req_o = '0;
    end

    // ============================================================
    // One access, launched after a falling edge
    task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                          input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        @(negedge sys_clk_i);
        cfg_req_o = '{valid: 1'b1, write: wr, dword: dw, be: be, wdata: wd};
        @(negedge sys_clk_i);
        ack = cfg_ack_i;
        rd = cfg_rdata_i;
        // Released dword and wdata lines show no stale value
        cfg_req_o = '{valid: 1'b0, write: wr, dword: ~dw, be: be, wdata: ~wd};
    endtask
endmodule

// ### verification/tb.sv
/*
 * Self-checking bench for the configuration header block: identity reads,
 * command writes with random byte enables, and random primary, secondary,
 * mastering and error traffic checked against a reference function.
 * Assumes the cfg_master_model partner and a 100 MHz clock.
 */
`timescale 1ns/100ps

module tb;
    localparam logic [15:0] MAKER = 16'h3e71;   // Arbitrary value
    localparam logic [15:0] PART  = 16'h0b42;   // Arbitrary value

    logic                     sys_clk_i = 1'b0;
    logic                     rst_i     = 1'b1;
    bridge_cfg_pkg::cfg_req_s cfg_req;
    bridge_cfg_pkg::bus_txn_s pri = '0;
    bridge_cfg_pkg::bus_txn_s sec = '0;
    logic                     ce   = 1'b1;
    logic                     pcix = 1'b0;
    logic                     fwd  = 1'b0;
    logic                     spl  = 1'b0;
    logic                     par  = 1'b0;
    logic                     serr = 1'b0;
    logic                     ack;
    logic [31:0]              rd;
    logic                     cfg_ack;
    logic [31:0]              cfg_rdata;
    logic [10:0]              outs;
    logic [10:0]              exp;
    logic [15:0]              cmd = 16'h0000;
    logic [31:0]              wd;
    logic [3:0]               be;
    logic [31:0]              r;
    logic [9:0]               pal [4] = '{10'h3c6, 10'h3c7, 10'h3c8, 10'h3c9};
    integer                   seed = 32'h6f8cfdba;
    int                       miscompares = 0;
    int                       comparisons = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    cfg_master_model cfg_master_model_inst (.sys_clk_i(sys_clk_i), .cfg_req_o(cfg_req),
        .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata));

    bridge_config_header_command #(.MAKER_CODE(MAKER), .PART_CODE(PART)) bridge_config_header_command_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .cfg_req_i(cfg_req), .cfg_ack_o(cfg_ack),
        .cfg_rdata_o(cfg_rdata), .pri_txn_i(pri), .pri_claim_o(outs[10]), .pri_vga_claim_o(outs[9]),
        .sec_txn_i(sec), .sec_claim_o(outs[8]), .pcix_mode_i(pcix), .fwd_req_i(fwd),
        .split_cpl_req_i(spl), .pri_master_start_o(outs[7]), .pri_split_start_o(outs[6]),
        .parity_err_i(par), .serr_event_i(serr), .parity_action_o(outs[5]),
        .primary_system_error_out_o(outs[4]), .primary_system_error_out_oe_o(outs[3]),
        .fbb_allowed_o(outs[2]), .stepping_allowed_o(outs[1]), .mwi_allowed_o(outs[0]));

    // ============================================================
    // Reference and helpers
    function automatic logic [10:0] exp_out(logic [15:0] c, bridge_cfg_pkg::bus_txn_s p,
                                            bridge_cfg_pkg::bus_txn_s s);
        logic vga;
        logic pc;
        logic sc;
        vga = c[5] & p.valid & (p.kind == bridge_cfg_pkg::KIND_IO) & p.write
              & (p.addr[9:0] inside {10'h3c6, 10'h3c8, 10'h3c9});
        pc = vga | (p.valid & p.in_window & ((p.kind == bridge_cfg_pkg::KIND_MEM & c[1])
             | (p.kind == bridge_cfg_pkg::KIND_IO & c[0])));
        sc = s.valid & s.in_window & c[2]
             & (s.kind == bridge_cfg_pkg::KIND_MEM | s.kind == bridge_cfg_pkg::KIND_IO);
        return {pc, vga, sc, fwd & c[2], spl & (pcix | c[2]), par & c[6], 1'b0, serr & c[8], 3'b000};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic rand_txn(output bridge_cfg_pkg::bus_txn_s t);
        logic [31:0] q;
        q = $random(seed);
        t = {q[0], bridge_cfg_pkg::txn_kind_e'(q[2:1]), q[3], q[4], 32'($random(seed))};
        if (q[6:5] != 2'b00)
            t.addr[9:0] = pal[q[8:7]];
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge sys_clk_i);
        miscompares++;
        finish_test();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        cfg_master_model_inst.access(1'b0, 6'h00, 4'hf, 32'h0, ack, rd);
        check(ack, 1);
        check(rd, {PART, MAKER});
        cfg_master_model_inst.access(1'b1, 6'h00, 4'hf, 32'hffffffff, ack, rd);
        cfg_master_model_inst.access(1'b0, 6'h00, 4'hf, 32'h0, ack, rd);
        check(rd, {PART, MAKER});
        cfg_master_model_inst.access(1'b0, 6'h3f, 4'hf, 32'h0, ack, rd);
        check(rd, 32'h0);
        $display("Identity test done");
        for (int i = 0; i < 40; i++)
        begin
            wd = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
            be = (i < 2) ? 4'hf : 4'($random(seed));
            cfg_master_model_inst.access(1'b1, 6'h01, be, wd, ack, rd);
            check(ack, 1);
            if (be[0])
                cmd[7:0] = wd[7:0] & 8'h67;
            if (be[1])
                cmd[15:8] = wd[15:8] & 8'h01;
            cfg_master_model_inst.access(1'b0, 6'h01, 4'hf, 32'h0, ack, rd);
            check(rd, {16'h0, cmd});
            if (i == 2)
            begin
                @(negedge sys_clk_i);
                ce = 1'b0;
                cfg_master_model_inst.access(1'b1, 6'h01, 4'hf, ~wd, ack, rd);
                ce = 1'b1;
                check(ack, 0);
                cfg_master_model_inst.access(1'b0, 6'h01, 4'hf, 32'h0, ack, rd);
                check(rd, {16'h0, cmd});
            end
            for (int j = 0; j < 26; j++)
            begin
                @(negedge sys_clk_i);
                if (j > 0)
                    check(outs, exp);
                rand_txn(pri);
                rand_txn(sec);
                r = $random(seed);
                {pcix, fwd, spl, par, serr} = r[4:0];
                ce = (j == 0) || (r[7:5] != 3'b000);
                if (ce)
                    exp = exp_out(cmd, pri, sec);
            end
            @(negedge sys_clk_i);
            check(outs, exp);
            ce = 1'b1;
        end
        $display("Command and traffic test done");
        @(negedge sys_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check(outs, 11'h000);
        rst_i = 1'b0;
        cfg_master_model_inst.access(1'b0, 6'h01, 4'hf, 32'h0, ack, rd);
        check(rd, 32'h0);
        $display("Reset test done");
        finish_test();
    end
endmodule
